/* File: rlre_pkg.sv */
// shared constants for the return-with-literal and rotate execution block
`default_nettype none
package rlre_pkg;
  localparam int          INSN_W        = 12;
  localparam int          DATA_W        = 8;
  localparam int          PC_W          = 9;
  // opcode fields
  localparam logic [3:0]  RETLIT_OP     = 4'h8;   // insn[11:8]
  localparam logic [5:0]  ROTL_OP       = 6'h0d;  // insn[11:6] = 0011 01
  localparam logic [5:0]  ROTR_OP       = 6'h0c;  // insn[11:6] = 0011 00
  localparam int          DEST_BIT      = 5;
  localparam int          OPC_MSB       = 11;     // top bit of every opcode field
  localparam int          RETLIT_LSB    = 8;      // low bit of the return opcode
  localparam int          ROT_LSB       = 6;      // low bit of the rotate opcodes
  localparam int          FADDR_W       = 5;
  // two-cycle return
  localparam int          RETLIT_CYCLES = 2;
  // reset values
  localparam logic [7:0]  ACC_RST       = 8'h00;
  localparam logic [8:0]  PC_RST        = 9'h000;
  localparam logic        CARRY_RST     = 1'h0;
  typedef enum logic {RLRE_EXEC, RLRE_FLUSH} rlre_state_t;
endpackage
`default_nettype wire

/* File: rlre_rotate.sv */
// rotate-through-carry datapath, purely combinational
`timescale 1ns/1ps
`default_nettype none
module rlre_rotate #(
  parameter int DW = 8
) (
  input  wire logic          dirLeft,
  input  wire logic [DW-1:0] srcData,
  input  wire logic          carryIn,
  output logic      [DW-1:0] result,
  output logic               carryOut
);
  // left: carry enters lsb, msb leaves; right: carry enters msb, lsb leaves
  assign result   = dirLeft ? {srcData[DW-2:0], carryIn} : {carryIn, srcData[DW-1:1]};
  assign carryOut = dirLeft ? srcData[DW-1] : srcData[0];
endmodule
`default_nettype wire

/* File: rlre_exec.sv */
// execute logic for return-with-literal and the two rotates through carry
//
// Contract
// - return_with_literal loads accumulator with instruction's low eight bits.
// - return_with_literal reloads program_counter from stack_top_entry.
// - return_with_literal takes two instruction cycles.
// - rotate_left_through_carry rotates file register left through carry, updates carry.
// - left rotate: destination 0 writes accumulator, 1 writes file register.
// - rotate_right_through_carry rotates file register right through carry, updates carry.
// - right rotate: destination 0 writes accumulator, 1 writes file register.
`timescale 1ns/1ps
`default_nettype none
module rlre_exec #(
  parameter int DW = rlre_pkg::DATA_W,
  parameter int PW = rlre_pkg::PC_W
) (
  input  wire logic                          ref_clk,
  input  wire logic                          rst,
  input  wire logic                          insnValid,
  input  wire logic [rlre_pkg::INSN_W-1:0]   insn,
  input  wire logic [PW-1:0]                 stackTopEntry,
  input  wire logic [DW-1:0]                 fileRdData,
  output logic      [rlre_pkg::FADDR_W-1:0]  fileAddr,
  output logic                               insnReady,
  output logic                               stackPop,
  output logic      [DW-1:0]                 accQ,
  output logic                               carryQ,
  output logic      [PW-1:0]                 pcLoadValue,
  output logic                               pcLoad,
  output logic                               fileWrEn,
  output logic      [rlre_pkg::FADDR_W-1:0]  fileWrAddr,
  output logic      [DW-1:0]                 fileWrData
);
  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  rlre_pkg::rlre_state_t stateQ, stateD;
  // dead cycle count derived from the package so it can be retuned in one place
  localparam logic [1:0] RetLast = 2'(rlre_pkg::RETLIT_CYCLES - 1);
  logic           [1:0] retCycQ;
  logic           [1:0] retCycD;
  wire logic         inExec  = (stateQ == rlre_pkg::RLRE_EXEC);
  wire logic         take    = insnValid && inExec;
  // opcode fields pulled out once so the compares below stay short
  wire logic [3:0]   retField = insn[rlre_pkg::OPC_MSB:rlre_pkg::RETLIT_LSB];
  wire logic [5:0]   rotField = insn[rlre_pkg::OPC_MSB:rlre_pkg::ROT_LSB];
  wire logic         isRet   = take && (retField == rlre_pkg::RETLIT_OP);
  wire logic         isRotL  = take && (rotField == rlre_pkg::ROTL_OP);
  wire logic         isRotR  = take && (rotField == rlre_pkg::ROTR_OP);
  wire logic         isRot   = isRotL || isRotR;
  wire logic         toFile  = insn[rlre_pkg::DEST_BIT];
  wire logic [DW-1:0] rotRes;
  wire logic          rotCarry;

  // file register read address comes straight from the f field
  assign fileAddr  = insn[rlre_pkg::FADDR_W-1:0];
  // busy during the second cycle of a return, the fetched word is discarded
  assign insnReady = inExec;
  assign stackPop  = isRet;
  // cycles spent on the current return, 1 in the first dead cycle
  assign retCycD   = isRet ? 2'h1 : (inExec ? 2'h0 : retCycQ + 2'h1);

  // the rotator reads the live carry, so back-to-back rotates chain through it
  rlre_rotate #(.DW(DW)) uRot (
    .dirLeft  (isRotL),
    .srcData  (fileRdData),
    .carryIn  (carryQ),
    .result   (rotRes),
    .carryOut (rotCarry)
  );

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  // return spends one extra cycle flushing the prefetched word
  always_comb begin
    case (stateQ)
      rlre_pkg::RLRE_EXEC:  stateD = isRet ? rlre_pkg::RLRE_FLUSH : rlre_pkg::RLRE_EXEC;
      rlre_pkg::RLRE_FLUSH: stateD = (retCycQ == RetLast) ? rlre_pkg::RLRE_EXEC : rlre_pkg::RLRE_FLUSH;
      default:              stateD = rlre_pkg::RLRE_EXEC;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stateQ  <= rlre_pkg::RLRE_EXEC;
      retCycQ <= 2'h0;
    end else begin
      stateQ  <= stateD;
      retCycQ <= retCycD;
    end
  end

  // ------------------------------------------------------------
  // architectural results
  // ------------------------------------------------------------
  // accumulator: literal on return, rotate result when destination is 0
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      accQ <= rlre_pkg::ACC_RST;
    end else if (isRet) begin
      accQ <= insn[DW-1:0];
    end else if (isRot && !toFile) begin
      accQ <= rotRes;
    end
  end

  // carry changes on both rotates, whatever the destination
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      carryQ <= rlre_pkg::CARRY_RST;
    end else if (isRot) begin
      carryQ <= rotCarry;
    end
  end

  // file write-back and pc reload, registered so data outputs come from flops
  // address is captured with the data so the writer always sees a matching pair
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fileWrEn    <= 1'b0;
      fileWrAddr  <= '0;
      fileWrData  <= '0;
      pcLoad      <= 1'b0;
      pcLoadValue <= rlre_pkg::PC_RST;
    end else begin
      fileWrEn    <= isRot && toFile;
      fileWrAddr  <= fileAddr;
      fileWrData  <= rotRes;
      pcLoad      <= isRet;
      if (isRet) begin
        pcLoadValue <= stackTopEntry;
      end
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  property p_ret_acc;
    @(posedge ref_clk) disable iff (rst) isRet |=> accQ == $past(insn[7:0]);
  endproperty
  a_ret_acc: assert property (p_ret_acc) else $error("literal not loaded");

  property p_ret_pc;
    @(posedge ref_clk) disable iff (rst) isRet |=> pcLoad && pcLoadValue == $past(stackTopEntry);
  endproperty
  a_ret_pc: assert property (p_ret_pc) else $error("pc not reloaded from stack");

  property p_ret_two;
    @(posedge ref_clk) disable iff (rst) isRet |=> !insnReady ##1 insnReady;
  endproperty
  a_ret_two: assert property (p_ret_two) else $error("return not two cycles");

  property p_rotl;
    @(posedge ref_clk) disable iff (rst)
      isRotL |=> carryQ == $past(fileRdData[7]) && fileWrData == {$past(fileRdData[6:0]), $past(carryQ)};
  endproperty
  a_rotl: assert property (p_rotl) else $error("left rotate wrong");

  property p_rotl_dest;
    @(posedge ref_clk) disable iff (rst)
      isRotL |=> (fileWrEn == $past(toFile)) && ($past(toFile) || accQ == fileWrData);
  endproperty
  a_rotl_dest: assert property (p_rotl_dest) else $error("left rotate destination wrong");

  property p_rotr;
    @(posedge ref_clk) disable iff (rst)
      isRotR |=> carryQ == $past(fileRdData[0]) && fileWrData == {$past(carryQ), $past(fileRdData[7:1])};
  endproperty
  a_rotr: assert property (p_rotr) else $error("right rotate wrong");

  property p_rotr_dest;
    @(posedge ref_clk) disable iff (rst)
      isRotR && toFile |=> fileWrEn && accQ == $past(accQ);
  endproperty
  a_rotr_dest: assert property (p_rotr_dest) else $error("right rotate destination wrong");

  property p_carry_hold;
    @(posedge ref_clk) disable iff (rst) !isRot |=> $stable(carryQ);
  endproperty
  a_carry_hold: assert property (p_carry_hold) else $error("carry changed without rotate");

  // a second pop in the dead cycle would unwind the return stack twice
  property p_pop_once;
    @(posedge ref_clk) disable iff (rst) stackPop |=> !stackPop;
  endproperty
  a_pop_once: assert property (p_pop_once) else $error("stack popped twice");

  // nothing architectural may move while the prefetched word is flushed
  property p_flush_quiet;
    @(posedge ref_clk) disable iff (rst)
      stateQ == rlre_pkg::RLRE_FLUSH |=> !fileWrEn && !pcLoad && $stable(accQ) && $stable(carryQ);
  endproperty
  a_flush_quiet: assert property (p_flush_quiet) else $error("state changed in dead cycle");

  // right rotate into the accumulator leaves the file register alone
  property p_rotr_acc;
    @(posedge ref_clk) disable iff (rst)
      isRotR && !toFile |=> !fileWrEn && accQ == fileWrData;
  endproperty
  a_rotr_acc: assert property (p_rotr_acc) else $error("right rotate to accumulator wrong");

  // left rotate back to the file keeps the accumulator and the address
  property p_rotl_keep;
    @(posedge ref_clk) disable iff (rst)
      isRotL && toFile |=> accQ == $past(accQ) && fileWrAddr == $past(fileAddr);
  endproperty
  a_rotl_keep: assert property (p_rotl_keep) else $error("left rotate to file wrong");

  // the reload strobe is a single pulse per return
  property p_pc_pulse;
    @(posedge ref_clk) disable iff (rst) pcLoad |=> !pcLoad;
  endproperty
  a_pc_pulse: assert property (p_pc_pulse) else $error("reload strobe held");

  c_ret:     cover property (@(posedge ref_clk) disable iff (rst) isRet ##2 isRotL);
  c_rotl_f:  cover property (@(posedge ref_clk) disable iff (rst) isRotL && toFile);
  c_rotr_w:  cover property (@(posedge ref_clk) disable iff (rst) isRotR && !toFile);
  c_rotr_f:  cover property (@(posedge ref_clk) disable iff (rst) isRotR && toFile);
  c_rotl_w:  cover property (@(posedge ref_clk) disable iff (rst) isRotL && !toFile);
endmodule
`default_nettype wire

/* File: testbench.sv */
// self-checking bench for the return-with-literal and rotate execution block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module testbench;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        insnValid = 1'b0;
  logic [11:0] insn = 12'h000;
  logic [8:0]  stackTopEntry = 9'h000;
  logic [7:0]  fileRdData = 8'h00;
  logic [4:0]  fileAddr, fileWrAddr;
  logic [7:0]  accQ, fileWrData;
  logic [8:0]  pcLoadValue;
  logic        insnReady, stackPop, carryQ, pcLoad, fileWrEn;
  logic [7:0]  acc = 8'h00;
  logic        cy = 1'b0;
  logic [31:0] seed = 32'h6b6b;
  int          miscompares = 0;
  int          n_checks = 0;

  rlre_exec dut (.ref_clk(ref_clk), .rst(rst), .insnValid(insnValid), .insn(insn),
    .stackTopEntry(stackTopEntry), .fileRdData(fileRdData), .fileAddr(fileAddr),
    .insnReady(insnReady), .stackPop(stackPop), .accQ(accQ), .carryQ(carryQ),
    .pcLoadValue(pcLoadValue), .pcLoad(pcLoad), .fileWrEn(fileWrEn),
    .fileWrAddr(fileWrAddr), .fileWrData(fileWrData));

  // free-running 100 MHz clock
  always #5 ref_clk = ~ref_clk;

  // repeatable stimulus source
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
  endfunction

  // rotate through carry as the rules describe it: {new carry, result}
  function automatic logic [8:0] rot_model(input logic left, input logic [7:0] fd, input logic c);
    return left ? {fd[7], fd[6:0], c} : {fd[0], c, fd[7:1]};
  endfunction

  // one instruction: drive after the edge, check comb then registered outputs
  task automatic run(input logic [11:0] w, input logic v, input logic [8:0] topEnt, input logic [7:0] fd);
    logic ret, rl, rr;
    logic [7:0] rot;
    logic nc;
    ret = v && w[11:8] == rlre_pkg::RETLIT_OP;
    rl = v && w[11:6] == rlre_pkg::ROTL_OP;
    rr = v && w[11:6] == rlre_pkg::ROTR_OP;
    {nc, rot} = rot_model(rl, fd, cy);
    insnValid = v; insn = w; stackTopEntry = topEnt; fileRdData = fd;
    #1;
    `CHK("fileAddr", w[4:0], fileAddr)
    `CHK("insnReady", 1'b1, insnReady)
    `CHK("stackPop", ret, stackPop)
    @(posedge ref_clk); #1;
    if (ret) acc = w[7:0];
    if (rl || rr) begin
      cy = nc;
      if (!w[rlre_pkg::DEST_BIT]) acc = rot;
    end
    `CHK("accQ", acc, accQ)
    `CHK("carryQ", cy, carryQ)
    `CHK("pcLoad", ret, pcLoad)
    `CHK("fileWrEn", (rl || rr) && w[5], fileWrEn)
    if (rl) `CHK("left result", rot, fileWrData)
    if (rr) `CHK("right result", rot, fileWrData)
    if (rr && w[5]) `CHK("fileWrAddr", w[4:0], fileWrAddr)
    if (ret) begin
      `CHK("pcLoadValue", topEnt, pcLoadValue)
      `CHK("busy cycle", 1'b0, insnReady)
      // a rotate or a second return offered in the dead cycle must be ignored
      insn = topEnt[0] ? {rlre_pkg::ROTL_OP, 6'h23} : {rlre_pkg::RETLIT_OP, ~w[7:0]};
      fileRdData = ~fd;
      #1;
      `CHK("dead pop", 1'b0, stackPop)
      @(posedge ref_clk); #1;
      `CHK("dead write", 1'b0, fileWrEn)
      `CHK("dead acc", acc, accQ)
      `CHK("dead carry", cy, carryQ)
      `CHK("pcLoad pulse", 1'b0, pcLoad)
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // main sequence: reset, corner cases, then random instruction mix
  initial begin
    logic [11:0] w;
    repeat (6) @(posedge ref_clk);
    #1 rst = 1'b0;
    `CHK("reset acc", rlre_pkg::ACC_RST, accQ)
    `CHK("reset ready", 1'b1, insnReady)
    run({rlre_pkg::ROTL_OP, 6'h05}, 1'b1, 9'h000, 8'he6);
    run({rlre_pkg::ROTR_OP, 6'h05}, 1'b1, 9'h000, 8'he6);
    run({rlre_pkg::ROTR_OP, 6'h3f}, 1'b1, 9'h000, 8'h01);
    run(12'h8ff, 1'b1, 9'h1ff, 8'h00);
    run(12'h800, 1'b1, 9'h100, 8'h00);
    run(12'h855, 1'b0, 9'h0aa, 8'h80);
    for (int i = 0; i < 400; i++) begin
      seed = lfsr(seed);
      case (seed[1:0])
        2'h0: w = {rlre_pkg::RETLIT_OP, seed[15:8]};
        2'h1: w = {rlre_pkg::ROTL_OP, seed[7:2]};
        2'h2: w = {rlre_pkg::ROTR_OP, seed[7:2]};
        default: w = seed[13:2];
      endcase
      run(w, seed[22:20] != 3'h0, seed[24:16], seed[31:24]);
    end
    results();
  end
endmodule
`default_nettype wire
